// ===== dma_ctrl_pkg.sv
package dma_ctrl_pkg;
  localparam int ADDR_W = 16;
  localparam logic [15:0] OFS_IRQ_STATUS = 16'h1014;
  localparam logic [15:0] OFS_INT_ENABLE = 16'h101c;
  localparam logic [15:0] OFS_MISSED_CNT = 16'h1020;
  localparam logic [15:0] OFS_WDT_TIMER = 16'h1024;
  localparam logic [15:0] OFS_AXI_MODE = 16'h1028;
  localparam logic [15:0] OFS_AXI_STATUS = 16'h102c;
  localparam logic [15:0] OFS_CUR_TX_DESC = 16'h1048;
  localparam logic [15:0] OFS_CUR_RX_DESC = 16'h104c;
  localparam logic [15:0] OFS_CUR_TX_BUF = 16'h1050;
  localparam logic [15:0] OFS_CUR_RX_BUF = 16'h1054;
  // Interrupt enable / status bit positions
  localparam int NORMAL_EN_BIT = 16;
  localparam int ABNORMAL_EN_BIT = 15;
  localparam int RX_DONE_BIT = 6;
  localparam logic [14:0] NORMAL_SRC_MASK = 15'h4045;
  localparam logic [14:0] ABNORMAL_SRC_MASK = 15'h27ba;
  localparam logic [16:0] INT_EN_WR_MASK = 17'h1e7ff;
  // Counter register fields
  localparam int MISS_OVF_BIT = 16;
  localparam int FIFO_CNT_LSB = 17;
  localparam int FIFO_OVF_BIT = 28;
  localparam int FIFO_CLR_LANE = 2;
  localparam int MISS_CLR_LANE = 0;
  // AXI mode fields
  localparam int LP_ACCEPT_BIT = 31;
  localparam int WAKE_QUAL_BIT = 30;
  localparam int WR_LIM_LSB = 20;
  localparam int RD_LIM_LSB = 16;
  localparam int ALIGNED_BIT = 12;
  localparam int BURST_PERM_LSB = 1;
  localparam logic [1:0] OSR_LIMIT_RST = 2'h1;
  localparam int WDT_UNIT_CYCLES = 256;

  typedef struct packed {
    logic wr_addr_issue;
    logic wr_resp_done;
    logic rd_addr_issue;
    logic rd_last_done;
    logic rd_busy;
    logic wr_busy;
  } axi_evt_t;

  typedef struct packed {
    logic [3:0] load;
    logic [3:0][31:0] addr;
  } ptr_upd_t;

  typedef struct packed {
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic [16:0] int_en;
    logic [14:0] status;
    logic [15:0] miss_cnt;
    logic miss_ovf;
    logic [10:0] fifo_cnt;
    logic fifo_ovf;
    logic [7:0] wdt_reload;
    logic [15:0] wdt_cnt;
    logic wdt_run;
    logic lp_en;
    logic wake_qual;
    logic [1:0] wr_lim;
    logic [1:0] rd_lim;
    logic [2:0] burst_perm;
    logic [2:0] wr_out;
    logic [2:0] rd_out;
    logic wr_allow;
    logic rd_allow;
    logic lp_grant;
    logic lp_exit;
    logic aligned;
    logic any_burst;
    logic [2:0] burst_ok;
    logic [1:0] ch_active;
    logic [3:0][31:0] ptr;
    logic irq;
  } dma_state_t;

  localparam dma_state_t STATE_RST = '{wr_lim: OSR_LIMIT_RST, rd_lim: OSR_LIMIT_RST,
    wr_allow: 1'b1, rd_allow: 1'b1, any_burst: 1'b1, burst_ok: 3'h7, default: '0};
endpackage : dma_ctrl_pkg

// ===== dma_ctrl_status.sv
`timescale 1ns/1ps
module dma_ctrl_status (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic ce,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [dma_ctrl_pkg::ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  input wire logic [3:0] reg_byte_lane_enable,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic [14:0] status_set,
  input wire logic rx_frame_done,
  input wire logic rx_descriptor_word1_irq_off,
  input wire logic rx_nobuf_discard,
  input wire logic rx_fifo_overflow,
  input wire logic lp_request,
  input wire logic rx_any_frame,
  input wire logic rx_wake_frame,
  input wire logic fixed_burst_setting,
  input wire logic aligned_beats_setting,
  input wire dma_ctrl_pkg::axi_evt_t axi_evt,
  input wire dma_ctrl_pkg::ptr_upd_t ptr_upd,
  output logic dma_irq,
  output logic low_power_grant,
  output logic low_power_exit_req,
  output logic write_issue_allow,
  output logic read_issue_allow,
  output logic aligned_burst_en,
  output logic any_burst_indicator,
  output logic [2:0] burst_len_ok
);
  dma_ctrl_pkg::dma_state_t st_ff;
  dma_ctrl_pkg::dma_state_t nxt_st;

  logic setup;
  logic access;
  logic [31:0] be_mask;
  logic [31:0] rd_word;
  logic rd_hit;
  logic [15:0] ofs;
  logic [31:0] cur_word;
  logic [31:0] wr_word;
  logic [14:0] w1c;
  logic rx_auto_done;
  logic wdt_start;
  logic wdt_expire;
  logic miss_clr;
  logic fifo_clr;
  logic [14:0] gated;

  assign prdata = st_ff.prdata;
  assign pready = st_ff.pready;
  assign pslverr = st_ff.pslverr;
  assign dma_irq = st_ff.irq;
  assign low_power_grant = st_ff.lp_grant;
  assign low_power_exit_req = st_ff.lp_exit;
  assign write_issue_allow = st_ff.wr_allow;
  assign read_issue_allow = st_ff.rd_allow;
  assign aligned_burst_en = st_ff.aligned;
  assign any_burst_indicator = st_ff.any_burst;
  assign burst_len_ok = st_ff.burst_ok;

  assign setup = psel && !penable;
  assign access = psel && penable && st_ff.pready;
  assign ofs = 16'(paddr);
  assign be_mask = {{8{pstrb[3]}}, {8{pstrb[2]}}, {8{pstrb[1]}}, {8{pstrb[0]}}};

  // Read mux, decoded from the byte address
  always_comb begin
    rd_hit = 1'b1;
    unique case (ofs)
      dma_ctrl_pkg::OFS_IRQ_STATUS: rd_word = {17'h0, st_ff.status};
      dma_ctrl_pkg::OFS_INT_ENABLE: rd_word = {15'h0, st_ff.int_en};
      dma_ctrl_pkg::OFS_MISSED_CNT: rd_word = {3'h0, st_ff.fifo_ovf, st_ff.fifo_cnt,
                                               st_ff.miss_ovf, st_ff.miss_cnt};
      dma_ctrl_pkg::OFS_WDT_TIMER: rd_word = {24'h0, st_ff.wdt_reload};
      dma_ctrl_pkg::OFS_AXI_MODE: rd_word = {st_ff.lp_en, st_ff.wake_qual, 8'h0,
                                             st_ff.wr_lim, 2'h0, st_ff.rd_lim, 3'h0,
                                             st_ff.aligned, 8'h0, st_ff.burst_perm,
                                             st_ff.any_burst};
      dma_ctrl_pkg::OFS_AXI_STATUS: rd_word = {30'h0, st_ff.ch_active};
      dma_ctrl_pkg::OFS_CUR_TX_DESC: rd_word = st_ff.ptr[0];
      dma_ctrl_pkg::OFS_CUR_RX_DESC: rd_word = st_ff.ptr[1];
      dma_ctrl_pkg::OFS_CUR_TX_BUF: rd_word = st_ff.ptr[2];
      dma_ctrl_pkg::OFS_CUR_RX_BUF: rd_word = st_ff.ptr[3];
      default: begin
        rd_word = 32'h0;
        rd_hit = 1'b0;
      end
    endcase
  end

  always_comb begin
    nxt_st = st_ff;
    cur_word = rd_word;
    wr_word = (cur_word & ~be_mask) | (pwdata & be_mask);
    w1c = 15'h0;
    miss_clr = 1'b0;
    fifo_clr = 1'b0;
    rx_auto_done = rx_frame_done && !rx_descriptor_word1_irq_off;
    wdt_start = rx_frame_done && rx_descriptor_word1_irq_off;
    wdt_expire = st_ff.wdt_run && (st_ff.wdt_cnt == 16'h1);
    gated = 15'h0;
    if (ce) begin
      // Bus: answer one cycle after setup, reads take their side effect at setup
      nxt_st.pready = setup;
      if (setup) begin
        nxt_st.prdata = pwrite ? 32'h0 : rd_word;
        nxt_st.pslverr = !rd_hit;
        if (!pwrite && ofs == dma_ctrl_pkg::OFS_MISSED_CNT) begin
          fifo_clr = reg_byte_lane_enable[dma_ctrl_pkg::FIFO_CLR_LANE];
          miss_clr = reg_byte_lane_enable[dma_ctrl_pkg::MISS_CLR_LANE];
        end
      end
      if (access && pwrite) begin
        unique case (ofs)
          dma_ctrl_pkg::OFS_IRQ_STATUS: w1c = 15'(pwdata & be_mask);
          dma_ctrl_pkg::OFS_INT_ENABLE:
            nxt_st.int_en = 17'(wr_word) & dma_ctrl_pkg::INT_EN_WR_MASK;
          dma_ctrl_pkg::OFS_WDT_TIMER: nxt_st.wdt_reload = wr_word[7:0];
          dma_ctrl_pkg::OFS_AXI_MODE: begin
            nxt_st.lp_en = wr_word[dma_ctrl_pkg::LP_ACCEPT_BIT];
            nxt_st.wake_qual = wr_word[dma_ctrl_pkg::WAKE_QUAL_BIT];
            nxt_st.wr_lim = wr_word[dma_ctrl_pkg::WR_LIM_LSB +: 2];
            nxt_st.rd_lim = wr_word[dma_ctrl_pkg::RD_LIM_LSB +: 2];
            nxt_st.burst_perm = wr_word[dma_ctrl_pkg::BURST_PERM_LSB +: 3];
          end
          default: begin
          end
        endcase
      end

      // Missed frame counters, an increment in the clearing cycle survives
      if (miss_clr) begin
        nxt_st.miss_cnt = {15'h0, rx_nobuf_discard};
        nxt_st.miss_ovf = rx_nobuf_discard && (&st_ff.miss_cnt); // Wrap beats the clear
      end else if (rx_nobuf_discard) begin
        nxt_st.miss_cnt = st_ff.miss_cnt + 16'h1;
        if (&st_ff.miss_cnt) nxt_st.miss_ovf = 1'b1;
      end
      if (fifo_clr) begin
        nxt_st.fifo_cnt = {10'h0, rx_fifo_overflow};
        nxt_st.fifo_ovf = rx_fifo_overflow && (&st_ff.fifo_cnt); // Wrap beats the clear
      end else if (rx_fifo_overflow) begin
        nxt_st.fifo_cnt = st_ff.fifo_cnt + 11'h1;
        if (&st_ff.fifo_cnt) nxt_st.fifo_ovf = 1'b1;
      end

      // Receive done watchdog
      if (rx_auto_done) begin
        nxt_st.wdt_run = 1'b0;
        nxt_st.wdt_cnt = 16'h0;
      end else if (wdt_start && st_ff.wdt_reload != 8'h0) begin
        nxt_st.wdt_run = 1'b1;
        nxt_st.wdt_cnt = 16'(32'(st_ff.wdt_reload) * dma_ctrl_pkg::WDT_UNIT_CYCLES);
      end else if (wdt_expire) begin
        nxt_st.wdt_run = 1'b0;
        nxt_st.wdt_cnt = 16'h0;
      end else if (st_ff.wdt_run) begin
        nxt_st.wdt_cnt = st_ff.wdt_cnt - 16'h1;
      end

      // Status: hardware set wins over software clear
      nxt_st.status = (st_ff.status & ~w1c) | status_set;
      if (rx_auto_done || (wdt_expire && !wdt_start)) begin
        nxt_st.status[dma_ctrl_pkg::RX_DONE_BIT] = 1'b1;
      end
      if (st_ff.int_en[dma_ctrl_pkg::NORMAL_EN_BIT]) begin
        gated = gated | dma_ctrl_pkg::NORMAL_SRC_MASK;
      end
      if (st_ff.int_en[dma_ctrl_pkg::ABNORMAL_EN_BIT]) begin
        gated = gated | dma_ctrl_pkg::ABNORMAL_SRC_MASK;
      end
      nxt_st.irq = |(nxt_st.status & st_ff.int_en[14:0] & gated);

      // Low power handshake
      nxt_st.lp_grant = st_ff.lp_en && lp_request;
      nxt_st.lp_exit = st_ff.lp_grant &&
                       (st_ff.wake_qual ? rx_wake_frame : rx_any_frame);

      // Outstanding request tracking
      nxt_st.wr_out = st_ff.wr_out + 3'(axi_evt.wr_addr_issue) - 3'(axi_evt.wr_resp_done);
      nxt_st.rd_out = st_ff.rd_out + 3'(axi_evt.rd_addr_issue) - 3'(axi_evt.rd_last_done);
      // Allow only while one more issue still fits under limit plus one
      nxt_st.wr_allow = nxt_st.wr_out <= {1'b0, nxt_st.wr_lim};
      nxt_st.rd_allow = nxt_st.rd_out <= {1'b0, nxt_st.rd_lim};

      nxt_st.aligned = aligned_beats_setting;
      nxt_st.any_burst = !fixed_burst_setting;
      nxt_st.burst_ok = nxt_st.burst_perm | {3{!fixed_burst_setting}};
      nxt_st.ch_active = {axi_evt.rd_busy, axi_evt.wr_busy};
      for (int i = 0; i < 4; i++) begin
        if (ptr_upd.load[i]) nxt_st.ptr[i] = ptr_upd.addr[i];
      end
    end
  end

  // All state in one register; reset zeroes the pointers
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_ff <= dma_ctrl_pkg::STATE_RST;
    end else begin
      st_ff <= nxt_st;
    end
  end

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  irq_gating_a: assert property (ce ##1 ce && st_ff.irq |->
    |(st_ff.status & $past(st_ff.int_en[14:0]) &
      (($past(st_ff.int_en[16]) ? dma_ctrl_pkg::NORMAL_SRC_MASK : 15'h0) |
       ($past(st_ff.int_en[15]) ? dma_ctrl_pkg::ABNORMAL_SRC_MASK : 15'h0))))
    else $error("interrupt without enabled source");

  summary_off_a: assert property (
    ce && !st_ff.int_en[16] && !st_ff.int_en[15] |=> !st_ff.irq)
    else $error("interrupt with both summaries off");

  src_off_a: assert property (
    ce && st_ff.int_en[14:0] == 15'h0 |=> !st_ff.irq)
    else $error("interrupt with no source enabled");

  normal_src_a: assert property (
    ce && st_ff.int_en[16] && st_ff.int_en[0] && st_ff.status[0] && !w1c[0] |=> st_ff.irq)
    else $error("enabled normal source gave no interrupt");

  abnormal_src_a: assert property (
    ce && st_ff.int_en[15] && st_ff.int_en[1] && st_ff.status[1] && !w1c[1] |=> st_ff.irq)
    else $error("enabled abnormal source gave no interrupt");

  wdt_expiry_a: assert property (ce && wdt_expire && !rx_frame_done |=>
    st_ff.status[dma_ctrl_pkg::RX_DONE_BIT] && !st_ff.wdt_run)
    else $error("watchdog expiry did not set receive done");

  wdt_load_a: assert property (ce && wdt_start && st_ff.wdt_reload != 8'h0 |=>
    st_ff.wdt_cnt == {$past(st_ff.wdt_reload), 8'h0})
    else $error("watchdog load not 256 per unit");

  wdt_start_a: assert property (
    ce && wdt_start && st_ff.wdt_reload != 8'h0 |=> st_ff.wdt_run)
    else $error("watchdog did not start");

  wdt_count_a: assert property (ce && st_ff.wdt_run && !rx_frame_done &&
    !wdt_expire |=> st_ff.wdt_cnt == $past(st_ff.wdt_cnt) - 16'h1)
    else $error("watchdog count step wrong");

  wdt_stop_a: assert property (
    ce && !st_ff.wdt_run && !rx_frame_done |=> !st_ff.wdt_run)
    else $error("watchdog restarted untriggered");

  wdt_reset_a: assert property (ce && rx_frame_done && !rx_descriptor_word1_irq_off |=>
    !st_ff.wdt_run && st_ff.status[dma_ctrl_pkg::RX_DONE_BIT])
    else $error("automatic receive done kept watchdog");

  miss_count_a: assert property (
    ce && !miss_clr && rx_nobuf_discard |=> st_ff.miss_cnt == $past(st_ff.miss_cnt) + 16'h1)
    else $error("discard counter step wrong");

  miss_wrap_a: assert property (
    ce && rx_nobuf_discard && (&st_ff.miss_cnt) |=> st_ff.miss_ovf)
    else $error("discard wrap flag lost");

  fifo_count_a: assert property (
    ce && !fifo_clr && rx_fifo_overflow |=> st_ff.fifo_cnt == $past(st_ff.fifo_cnt) + 11'h1)
    else $error("fifo counter step wrong");

  fifo_wrap_a: assert property (
    ce && rx_fifo_overflow && (&st_ff.fifo_cnt) |=> st_ff.fifo_ovf)
    else $error("fifo wrap flag lost");

  miss_clear_a: assert property (ce && setup && !pwrite && miss_clr &&
    !rx_nobuf_discard |=> st_ff.miss_cnt == 16'h0 && !st_ff.miss_ovf)
    else $error("discard counter not cleared");

  fifo_clear_a: assert property (ce && setup && !pwrite && fifo_clr &&
    !rx_fifo_overflow |=> st_ff.fifo_cnt == 11'h0 && !st_ff.fifo_ovf)
    else $error("fifo counter not cleared");

  fifo_keep_a: assert property (ce && setup && !pwrite &&
    ofs == dma_ctrl_pkg::OFS_MISSED_CNT && !reg_byte_lane_enable[2] && !rx_fifo_overflow
    |=> $stable(st_ff.fifo_cnt))
    else $error("fifo counter cleared without lane");

  miss_keep_a: assert property (ce && setup && !pwrite &&
    ofs == dma_ctrl_pkg::OFS_MISSED_CNT && !reg_byte_lane_enable[0] && !rx_nobuf_discard
    |=> $stable(st_ff.miss_cnt))
    else $error("discard counter cleared without lane");

  wr_limit_a: assert property (st_ff.wr_out <= {1'b0, st_ff.wr_lim} + 3'h1)
    else $error("write outstanding over limit");

  rd_limit_a: assert property (st_ff.rd_out <= {1'b0, st_ff.rd_lim} + 3'h1)
    else $error("read outstanding over limit");

  lp_deny_a: assert property (ce && !st_ff.lp_en |=> !st_ff.lp_grant)
    else $error("low power granted while disabled");

  lp_grant_a: assert property (
    ce && st_ff.lp_en && lp_request |=> low_power_grant)
    else $error("low power request not accepted");

  exit_any_a: assert property (
    ce && st_ff.lp_grant && !st_ff.wake_qual && rx_any_frame |=> low_power_exit_req)
    else $error("any frame did not request exit");

  exit_wake_a: assert property (
    ce && st_ff.wake_qual && !rx_wake_frame |=> !low_power_exit_req)
    else $error("exit requested without wake frame");

  aligned_a: assert property (
    ce |=> aligned_burst_en == $past(aligned_beats_setting))
    else $error("aligned beats mirror wrong");

  any_burst_a: assert property (
    ce |=> any_burst_indicator != $past(fixed_burst_setting))
    else $error("undefined burst not inverse of fixed");

  burst_ok_a: assert property (ce ##1 st_ff.any_burst |-> &st_ff.burst_ok)
    else $error("burst refused with undefined burst");

  burst_perm_a: assert property (
    ce ##1 !st_ff.any_burst |-> st_ff.burst_ok == st_ff.burst_perm)
    else $error("fixed burst not limited to permits");

  ch_active_a: assert property (
    ce |=> st_ff.ch_active == $past({axi_evt.rd_busy, axi_evt.wr_busy}))
    else $error("channel activity wrong");

  ptr_load_a: assert property (
    ce && ptr_upd.load[0] |=> st_ff.ptr[0] == $past(ptr_upd.addr[0]))
    else $error("pointer not loaded");

  ptr_hold_a: assert property (
    ce && ptr_upd.load == 4'h0 |=> $stable(st_ff.ptr))
    else $error("pointer changed without load");

  status_set_a: assert property (ce && status_set[1] |=> st_ff.status[1])
    else $error("status set lost to clear");

  status_clear_a: assert property (
    ce && w1c[1] && !status_set[1] |=> !st_ff.status[1])
    else $error("status not cleared by write one");

  pslverr_a: assert property (
    ce && setup && !rd_hit |=> pslverr && prdata == 32'h0)
    else $error("unmapped access not refused");

  prdata_hold_a: assert property (
    ce && !setup |=> $stable(prdata))
    else $error("read data changed outside setup");

  ready_a: assert property (ce && setup |=> pready ##1 (!pready || !ce))
    else $error("bus answer timing");

  ce_freeze_a: assert property (!ce |=> $stable(st_ff))
    else $error("state moved with clock enable low");
endmodule : dma_ctrl_status

// ===== axi_far_model.sv
`timescale 1ns/1ps
module axi_far_model (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic go,
  input wire logic write_issue_allow,
  input wire logic read_issue_allow,
  output dma_ctrl_pkg::axi_evt_t evt,
  output int wr_peak,
  output int rd_peak
);
  int wo, ro, wt, rt;
  logic wg, rg;
  // Issues spaced three cycles apart so that allow has caught up
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      evt <= '0;
      {wo, ro, wt, rt, wr_peak, rd_peak} <= '0;
      {wg, rg} <= '0;
    end else begin
      evt.wr_addr_issue <= go && write_issue_allow && !evt.wr_addr_issue && !wg;
      evt.rd_addr_issue <= go && read_issue_allow && !evt.rd_addr_issue && !rg;
      wg <= evt.wr_addr_issue;
      rg <= evt.rd_addr_issue;
      // Slow memory: one completion each eight cycles
      evt.wr_resp_done <= wo > 0 && wt == 7;
      evt.rd_last_done <= ro > 0 && rt == 7;
      wt <= wo > 0 ? (wt + 1) % 8 : 0;
      rt <= ro > 0 ? (rt + 1) % 8 : 0;
      wo <= wo + int'(evt.wr_addr_issue) - int'(evt.wr_resp_done);
      ro <= ro + int'(evt.rd_addr_issue) - int'(evt.rd_last_done);
      wr_peak <= wo > wr_peak ? wo : wr_peak;
      rd_peak <= ro > rd_peak ? ro : rd_peak;
      evt.wr_busy <= wo != 0;
      evt.rd_busy <= ro != 0;
    end
  end
endmodule : axi_far_model

// ===== test_eth_dma_irq_axi_config.sv
`timescale 1ns/1ps
module test_eth_dma_irq_axi_config;
  logic pclk, presetn, ce, psel, penable, pwrite, pready, pslverr, dma_irq, go, er;
  logic [dma_ctrl_pkg::ADDR_W-1:0] paddr;
  logic [31:0] pwdata, prdata, rd, g, o;
  logic [3:0] pstrb, reg_byte_lane_enable;
  logic [14:0] status_set;
  logic rx_frame_done, rx_descriptor_word1_irq_off, rx_nobuf_discard, rx_fifo_overflow;
  logic lp_request, rx_any_frame, rx_wake_frame, fixed_burst_setting, aligned_beats_setting;
  logic low_power_grant, low_power_exit_req, write_issue_allow, read_issue_allow;
  logic aligned_burst_en, any_burst_indicator;
  logic [2:0] burst_len_ok;
  dma_ctrl_pkg::axi_evt_t axi_evt;
  dma_ctrl_pkg::ptr_upd_t ptr_upd;
  int err_count, n_tests, wr_peak, rd_peak;
  dma_ctrl_status u_dma_ctrl_status (.pclk, .presetn, .ce, .psel, .penable, .pwrite, .paddr,
    .pwdata, .pstrb, .reg_byte_lane_enable, .prdata, .pready, .pslverr, .status_set,
    .rx_frame_done, .rx_descriptor_word1_irq_off, .rx_nobuf_discard, .rx_fifo_overflow,
    .lp_request, .rx_any_frame, .rx_wake_frame, .fixed_burst_setting, .aligned_beats_setting,
    .axi_evt, .ptr_upd, .dma_irq, .low_power_grant, .low_power_exit_req, .write_issue_allow,
    .read_issue_allow, .aligned_burst_en, .any_burst_indicator, .burst_len_ok);
  axi_far_model u_axi_far_model (.pclk, .presetn, .go, .write_issue_allow, .read_issue_allow,
    .evt(axi_evt), .wr_peak, .rd_peak);
  initial begin
    pclk = 0;
    forever #4 pclk = ~pclk;
  end
  initial begin
    repeat (90000) @(posedge pclk);
    err_count++;
    end_of_test();
  end
  task end_of_test;
    if (err_count == 0 && n_tests > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask : end_of_test
  task chk(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      err_count++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  task apb(input logic w, input logic [15:0] a, input logic [31:0] d, input logic [3:0] ln);
    int i;
    @(posedge pclk);
    {psel, penable, pwrite, paddr, pwdata} <= {2'b10, w, a, d};
    pstrb <= w ? 4'hf : 4'h0;
    reg_byte_lane_enable <= ln;
    @(posedge pclk);
    penable <= 1;
    i = 0;
    do begin
      @(posedge pclk);
      i++;
    end while (pready !== 1'b1 && i < 20);
    if (pready !== 1'b1) begin
      err_count++;
      end_of_test();
    end
    rd = prdata;
    er = pslverr;
    {psel, penable} <= 2'b00;
  endtask : apb
  task rdc(input logic [15:0] a, input logic [3:0] ln, input logic [31:0] e);
    apb(0, a, 32'h0, ln);
    chk(rd, e);
  endtask : rdc
  task settle;
    repeat (2) @(posedge pclk);
    #1;
  endtask : settle
  task frame(input logic off);
    @(posedge pclk);
    {rx_frame_done, rx_descriptor_word1_irq_off} <= {1'b1, off};
    @(posedge pclk);
    rx_frame_done <= 0;
  endtask : frame
  task lp(input logic any, input logic e);
    @(posedge pclk);
    {rx_any_frame, rx_wake_frame} <= {any, !any};
    @(posedge pclk);
    {rx_any_frame, rx_wake_frame} <= 2'b00;
    #1 chk(low_power_exit_req, e);
  endtask : lp
  initial begin
    {psel, penable, pwrite, paddr, pwdata, pstrb, reg_byte_lane_enable, status_set} = '0;
    {rx_frame_done, rx_descriptor_word1_irq_off, rx_nobuf_discard, rx_fifo_overflow} = '0;
    {lp_request, rx_any_frame, rx_wake_frame, fixed_burst_setting, aligned_beats_setting} = '0;
    {ptr_upd, go, err_count, n_tests, ce, presetn} = '0;
    ce = 1;
    repeat (4) @(posedge pclk);
    presetn <= 1;
    rdc(16'h101c, 4'h0, 32'h0);
    rdc(16'h1020, 4'h0, 32'h0);
    rdc(16'h1028, 4'h0, 32'h00110001);
    for (int k = 0; k < 4; k++) rdc(16'h1048 + 16'(4 * k), 4'h0, 32'h0);
    apb(0, 16'h1030, 32'h0, 4'h0);
    chk({31'h0, er}, 32'h1);
    chk(rd, 32'h0);
    // Each source against own enable, wrong group, own group
    for (int n = 0; n < 15; n++) begin
      if (!(dma_ctrl_pkg::NORMAL_SRC_MASK[n] | dma_ctrl_pkg::ABNORMAL_SRC_MASK[n])) continue;
      g = dma_ctrl_pkg::NORMAL_SRC_MASK[n] ? 32'h10000 : 32'h8000;
      o = g ^ 32'h18000;
      @(posedge pclk);
      status_set <= 15'h1 << n;
      @(posedge pclk);
      status_set <= '0;
      apb(1, 16'h101c, o | (32'h1 << n), 4'h0);
      settle();
      chk(dma_irq, 0);
      apb(1, 16'h101c, g, 4'h0);
      settle();
      chk(dma_irq, 0);
      apb(1, 16'h101c, g | (32'h1 << n), 4'h0);
      settle();
      chk(dma_irq, 1);
      rdc(16'h101c, 4'h0, g | (32'h1 << n));
      rdc(16'h1014, 4'h0, 32'h1 << n);
      apb(1, 16'h1014, 32'h1 << n, 4'h0);
      settle();
      chk(dma_irq, 0);
    end
    for (int k = 0; k < 3; k++) begin
      @(posedge pclk);
      {rx_nobuf_discard, rx_fifo_overflow} <= {1'b1, k < 2};
      @(posedge pclk);
      {rx_nobuf_discard, rx_fifo_overflow} <= 2'b00;
    end
    rdc(16'h1020, 4'h4, 32'h00040003);
    rdc(16'h1020, 4'h1, 32'h3);
    rdc(16'h1020, 4'h0, 32'h0);
    @(posedge pclk);
    {ce, rx_nobuf_discard} <= 2'b01;
    @(posedge pclk);
    {ce, rx_nobuf_discard} <= 2'b10;
    rdc(16'h1020, 4'h0, 32'h0);
    @(posedge pclk);
    {rx_nobuf_discard, rx_fifo_overflow} <= 2'b11;
    repeat (65536) @(posedge pclk);
    {rx_nobuf_discard, rx_fifo_overflow} <= 2'b00;
    rdc(16'h1020, 4'h5, 32'h10010000);
    apb(1, 16'h1024, 32'h2, 4'h0);
    rdc(16'h1024, 4'h0, 32'h2);
    frame(1);
    repeat (500) @(posedge pclk);
    rdc(16'h1014, 4'h0, 32'h0);
    repeat (20) @(posedge pclk);
    rdc(16'h1014, 4'h0, 32'h40);
    apb(1, 16'h1014, 32'h40, 4'h0);
    repeat (600) @(posedge pclk);
    rdc(16'h1014, 4'h0, 32'h0);
    frame(1);
    repeat (100) @(posedge pclk);
    frame(0);
    rdc(16'h1014, 4'h0, 32'h40);
    apb(1, 16'h1014, 32'h40, 4'h0);
    repeat (600) @(posedge pclk);
    rdc(16'h1014, 4'h0, 32'h0);
    lp_request <= 1;
    settle();
    chk(low_power_grant, 0);
    apb(1, 16'h1028, 32'h80110000, 4'h0);
    settle();
    chk(low_power_grant, 1);
    lp(1, 1);
    apb(1, 16'h1028, 32'hc0110000, 4'h0);
    lp(1, 0);
    lp(0, 1);
    @(posedge pclk);
    {fixed_burst_setting, aligned_beats_setting} <= 2'b11;
    apb(1, 16'h1028, 32'h0011000a, 4'h0);
    settle();
    chk({any_burst_indicator, aligned_burst_en, burst_len_ok}, 5'b01101);
    rdc(16'h1028, 4'h0, 32'h0011100a);
    fixed_burst_setting <= 0;
    settle();
    chk({any_burst_indicator, burst_len_ok}, 4'hf);
    apb(1, 16'h1028, 32'h00130000, 4'h0);
    go <= 1;
    repeat (100) @(posedge pclk);
    rdc(16'h102c, 4'h0, 32'h3);
    go <= 0;
    repeat (100) @(posedge pclk);
    chk({wr_peak[3:0], rd_peak[3:0]}, 8'h24);
    rdc(16'h102c, 4'h0, 32'h0);
    for (int k = 0; k < 4; k++) begin
      @(posedge pclk);
      ptr_upd.load <= 4'h1 << k;
      ptr_upd.addr[k] <= 32'ha5a50000 | 32'(k);
      @(posedge pclk);
      ptr_upd.load <= 4'h0;
    end
    apb(1, 16'h1048, 32'hffffffff, 4'h0);
    for (int k = 0; k < 4; k++) begin
      rdc(16'h1048 + 16'(4 * k), 4'h0, 32'ha5a50000 | 32'(k));
    end
    end_of_test();
  end
endmodule : test_eth_dma_irq_axi_config
